// [ccs_pkg.sv]
// shared constants for the clock multiplier and clock select block
package ccs_pkg;

    // ------------------------------------------------------------
    // register map: indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] CCS_IDX_MUL_CTRL = 8'hB9;
    localparam logic [7:0] CCS_IDX_CLK_SEL = 8'hBA;
    localparam logic [7:0] CCS_IDX_STATUS = 8'hBB;
    localparam int CCS_ADDR_W = 10;
    localparam logic [CCS_ADDR_W-1:0] CCS_ADDR_MUL_CTRL = {CCS_IDX_MUL_CTRL, 2'b00};
    localparam logic [CCS_ADDR_W-1:0] CCS_ADDR_CLK_SEL = {CCS_IDX_CLK_SEL, 2'b00};
    localparam logic [CCS_ADDR_W-1:0] CCS_ADDR_STATUS = {CCS_IDX_STATUS, 2'b00};

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CCS_MUL_EN_BIT = 7;
    localparam int CCS_MUL_INIT_BIT = 6;
    localparam int CCS_MUL_RDY_BIT = 5;
    localparam int CCS_MUL_SEL_LSB = 0;
    localparam int CCS_USB_SEL_LSB = 4;
    localparam int CCS_SYS_SEL_LSB = 0;
    localparam int CCS_ST_XTAL_BIT = 0;
    localparam int CCS_ST_SYS_BUSY_BIT = 1;
    localparam int CCS_ST_USB_BUSY_BIT = 2;
    localparam logic [7:0] CCS_MUL_CTRL_RST = 8'h00;
    localparam logic [7:0] CCS_CLK_SEL_RST = 8'h00;

    // ------------------------------------------------------------
    // source encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CCS_MSEL_INT = 2'h0;
    localparam logic [1:0] CCS_MSEL_EXT = 2'h1;
    localparam logic [1:0] CCS_MSEL_EXT_DIV2 = 2'h2;
    localparam logic [2:0] CCS_SYS_INT = 3'h0;
    localparam logic [2:0] CCS_SYS_EXT = 3'h1;
    localparam logic [2:0] CCS_SYS_MUL_DIV2 = 3'h2;
    localparam logic [2:0] CCS_SYS_MUL = 3'h3;
    localparam logic [2:0] CCS_SYS_LFO = 3'h4;
    localparam logic [2:0] CCS_USB_MUL = 3'h0;
    localparam logic [2:0] CCS_USB_INT_DIV2 = 3'h1;
    localparam logic [2:0] CCS_USB_EXT = 3'h2;
    localparam logic [2:0] CCS_USB_EXT_DIV2 = 3'h3;
    localparam logic [2:0] CCS_USB_EXT_DIV3 = 3'h4;
    localparam logic [2:0] CCS_USB_EXT_DIV4 = 3'h5;
    localparam logic [2:0] CCS_USB_MAX = 3'h5;
    localparam logic [1:0] CCS_XMODE_CRYSTAL = 2'h3;
    localparam logic [1:0] CCS_DIV3_LAST = 2'h2;

    // multiplier sequencing, gray coded along off-enabled-init-ready
    typedef enum logic [1:0] {
        CCS_MUL_OFF = 2'b00,
        CCS_MUL_ENABLED = 2'b01,
        CCS_MUL_INIT = 2'b11,
        CCS_MUL_READY = 2'b10
    } ccs_mul_state_t;

endpackage : ccs_pkg

// [ccs_glitch_mux.sv]
// glitch free selector over sampled clock sources
`timescale 1ns/100ps

module ccs_glitch_mux #(
    parameter int N = 8,
    parameter int SW = 3
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [N-1:0] src_in,
    input wire logic [SW-1:0] sel_in,
    output logic clk_out,
    output logic busy_out
);

    logic [SW-1:0] cur_r;
    logic out_r;
    logic park_r;

    // -----------------------------------------------------------
    // switch sequence
    // -----------------------------------------------------------
    // the old source is only left while low and the new one is only
    // joined while low, so no high phase is ever cut short
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur_r <= '0;
            out_r <= 1'b0;
            park_r <= 1'b0;
        end else if (!park_r && sel_in == cur_r) begin
            out_r <= src_in[cur_r];
        end else if (!park_r) begin
            out_r <= src_in[cur_r]; // finish the running high phase
            park_r <= !src_in[cur_r];
        end else begin
            out_r <= 1'b0; // parked low
            if (!src_in[sel_in]) begin
                cur_r <= sel_in;
                park_r <= 1'b0;
            end
        end
    end

    assign clk_out = out_r;
    assign busy_out = park_r;

endmodule : ccs_glitch_mux

// [ccs_clock_control.sv]
// clock multiplier control, system and usb clock selection
//
// Overview of operation
// - multiplier output is four times its input, 12 MHz gives 48 MHz
// - control bit 7 enables the multiplier, clearing it disables it
// - init bit zero at enable; writing one while enabled starts initialization
// - control bit 5 is read only ready flag, one once locked
// - control bits 4 to 2 read zero, writes ignored
// - input select: 00 internal, 01 external, 10 external/2, 11 reserved
// - internal oscillator usable immediately, no settling wait
// - hardware sets crystal valid once external oscillator settled
// - external oscillator still clocks timers, counters and usb
// - system clock switchable on the fly among settled sources
// - usb select bits 6 to 4: multiplier, int/2, ext, ext/2, /3, /4
// - system select bits 2 to 0: int, ext, mul/2, mul, low frequency
// - undivided multiplier system option only on 48 MHz variants
// - select bits 7 and 3 read zero, writes ignored
// - external mode 110 crystal, 111 crystal with divide by two
// - crystal valid reads zero unless crystal mode running and stable
`timescale 1ns/100ps

module ccs_clock_control #(
    parameter bit HAS_48MHZ = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [ccs_pkg::CCS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic int_osc_in,
    input wire logic ext_osc_in,
    input wire logic lf_osc_in,
    input wire logic mul_clk_in,
    input wire logic mul_lock_in,
    input wire logic [2:0] external_oscillator_mode_in,
    input wire logic xtal_settled_in,
    output logic multiplier_enable_out,
    output logic multiplier_initialize_out,
    output logic mul_ref_clk_out,
    output logic sys_clk_out,
    output logic usb_clk_out,
    output logic periph_ext_clk_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0] mul_ctrl_r;
    logic [2:0] usb_sel_r;
    logic [2:0] sys_sel_r;
    ccs_pkg::ccs_mul_state_t mul_st_r;
    logic lock_meta_r;
    logic lock_sync_r;
    logic mul_gate_r;
    logic xtal_valid_r;
    logic int_prev_r;
    logic ext_prev_r;
    logic mul_prev_r;
    logic int_div2_r;
    logic mul_div2_r;
    logic [2:0] ext_cnt_r;
    logic [1:0] ext_cnt3_r;
    logic ext_div3_r;
    logic ref_r;
    logic periph_r;
    logic wr_go;
    logic wr_lane0;
    logic mul_ready;
    logic mul_gated;
    logic [7:0] sys_src;
    logic [7:0] usb_src;
    logic sys_clk;
    logic usb_clk;
    logic sys_busy;
    logic usb_busy;
    logic [7:0] mul_ctrl_rd;
    logic [7:0] clk_sel_rd;
    logic [7:0] status_rd;

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    // the write lands at the edge where waitrequest is seen low
    assign wr_go = avs_write_in && !wait_r;
    assign wr_lane0 = wr_go && avs_byteenable_in[0];

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read_in || avs_write_in) && wait_r);
        end
    end

    // readback values; unused bits are constant zero
    assign mul_ctrl_rd = {mul_ctrl_r[ccs_pkg::CCS_MUL_EN_BIT],
                          mul_ctrl_r[ccs_pkg::CCS_MUL_INIT_BIT],
                          mul_ready, 3'h0, mul_ctrl_r[1:0]};
    assign clk_sel_rd = {1'b0, usb_sel_r, 1'b0, sys_sel_r};
    assign status_rd = {5'h00, usb_busy, sys_busy, xtal_valid_r};

    // read data is latched at the wait cycle edge, while waitrequest is still high, and stands after
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_in && wait_r) begin
            unique case (avs_address_in)
                ccs_pkg::CCS_ADDR_MUL_CTRL: rdata_r <= {24'h00_0000, mul_ctrl_rd};
                ccs_pkg::CCS_ADDR_CLK_SEL: rdata_r <= {24'h00_0000, clk_sel_rd};
                ccs_pkg::CCS_ADDR_STATUS: rdata_r <= {24'h00_0000, status_rd};
                default: rdata_r <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    assign avs_readdata_out = rdata_r;
    assign avs_waitrequest_out = wait_r;

    // ------------------------------------------------------------
    // multiplier control register
    // ------------------------------------------------------------
    // init only sticks while the multiplier is already enabled; a write
    // that sets enable and init together starts enabled but not init
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mul_ctrl_r <= ccs_pkg::CCS_MUL_CTRL_RST;
        end else if (wr_lane0 && avs_address_in == ccs_pkg::CCS_ADDR_MUL_CTRL) begin
            mul_ctrl_r[ccs_pkg::CCS_MUL_EN_BIT] <=
                avs_writedata_in[ccs_pkg::CCS_MUL_EN_BIT];
            mul_ctrl_r[ccs_pkg::CCS_MUL_INIT_BIT] <=
                avs_writedata_in[ccs_pkg::CCS_MUL_INIT_BIT] &&
                avs_writedata_in[ccs_pkg::CCS_MUL_EN_BIT] &&
                mul_ctrl_r[ccs_pkg::CCS_MUL_EN_BIT];
            mul_ctrl_r[1:0] <= avs_writedata_in[1:0];
        end
    end

    // ------------------------------------------------------------
    // clock select register
    // ------------------------------------------------------------
    // reserved codes are refused so the muxes never park on a dead source
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            usb_sel_r <= ccs_pkg::CCS_CLK_SEL_RST[6:4];
            sys_sel_r <= ccs_pkg::CCS_CLK_SEL_RST[2:0];
        end else if (wr_lane0 && avs_address_in == ccs_pkg::CCS_ADDR_CLK_SEL) begin
            if (avs_writedata_in[6:4] <= ccs_pkg::CCS_USB_MAX) begin
                usb_sel_r <= avs_writedata_in[6:4];
            end
            if (avs_writedata_in[2:0] <= ccs_pkg::CCS_SYS_LFO &&
                (HAS_48MHZ || avs_writedata_in[2:0] != ccs_pkg::CCS_SYS_MUL)) begin
                sys_sel_r <= avs_writedata_in[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // multiplier sequencing and lock
    // ------------------------------------------------------------
    // lock from the analog macro is asynchronous, two flops
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lock_meta_r <= 1'b0;
            lock_sync_r <= 1'b0;
            mul_gate_r <= 1'b0;
        end else begin
            lock_meta_r <= mul_lock_in;
            lock_sync_r <= lock_meta_r;
            if (!mul_clk_in) begin
                mul_gate_r <= mul_ready; // no runt
            end
        end
    end

    // ready falls at once if enable or lock is lost
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mul_st_r <= ccs_pkg::CCS_MUL_OFF;
        end else if (!mul_ctrl_r[ccs_pkg::CCS_MUL_EN_BIT]) begin
            mul_st_r <= ccs_pkg::CCS_MUL_OFF;
        end else begin
            unique case (mul_st_r)
                ccs_pkg::CCS_MUL_OFF: mul_st_r <= ccs_pkg::CCS_MUL_ENABLED;
                ccs_pkg::CCS_MUL_ENABLED: begin
                    if (mul_ctrl_r[ccs_pkg::CCS_MUL_INIT_BIT]) begin
                        mul_st_r <= ccs_pkg::CCS_MUL_INIT;
                    end
                end
                ccs_pkg::CCS_MUL_INIT: begin
                    if (lock_sync_r) begin
                        mul_st_r <= ccs_pkg::CCS_MUL_READY;
                    end
                end
                ccs_pkg::CCS_MUL_READY: begin
                    if (!lock_sync_r) begin
                        mul_st_r <= ccs_pkg::CCS_MUL_INIT;
                    end
                end
            endcase
        end
    end

    assign mul_ready = (mul_st_r == ccs_pkg::CCS_MUL_READY);
    assign multiplier_enable_out = mul_ctrl_r[ccs_pkg::CCS_MUL_EN_BIT];
    assign multiplier_initialize_out = mul_st_r[1];
    // the macro multiplies the reference by four; it is passed on only once locked
    assign mul_gated = mul_clk_in && mul_gate_r;

    // ------------------------------------------------------------
    // crystal valid flag
    // ------------------------------------------------------------
    // only meaningful in the crystal modes, otherwise held at zero
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            xtal_valid_r <= 1'b0;
        end else begin
            xtal_valid_r <= xtal_settled_in &&
                external_oscillator_mode_in[2:1] == ccs_pkg::CCS_XMODE_CRYSTAL;
        end
    end

    // ------------------------------------------------------------
    // source dividers on sampled oscillator edges
    // ------------------------------------------------------------
    // sources are sampled, so they must run below half the sample rate
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
            mul_prev_r <= 1'b0;
            int_div2_r <= 1'b0;
            mul_div2_r <= 1'b0;
            ext_cnt_r <= 3'h0;
            ext_cnt3_r <= 2'h0;
            ext_div3_r <= 1'b0;
        end else begin
            int_prev_r <= int_osc_in;
            ext_prev_r <= ext_osc_in;
            mul_prev_r <= mul_gated;
            if (int_osc_in && !int_prev_r) begin
                int_div2_r <= !int_div2_r;
            end
            if (mul_gated && !mul_prev_r) begin
                mul_div2_r <= !mul_div2_r;
            end
            if (ext_osc_in && !ext_prev_r) begin
                ext_cnt_r <= ext_cnt_r + 3'h1;
                ext_cnt3_r <= (ext_cnt3_r == ccs_pkg::CCS_DIV3_LAST) ? 2'h0 : ext_cnt3_r + 2'h1;
                ext_div3_r <= (ext_cnt3_r == ccs_pkg::CCS_DIV3_LAST);
            end
        end
    end

    // ------------------------------------------------------------
    // multiplier reference and peripheral clock
    // ------------------------------------------------------------
    // external divided by eight keeps timers running whatever the system source
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_r <= 1'b0;
            periph_r <= 1'b0;
        end else begin
            unique case (mul_ctrl_r[1:0])
                ccs_pkg::CCS_MSEL_INT: ref_r <= int_osc_in;
                ccs_pkg::CCS_MSEL_EXT: ref_r <= ext_osc_in;
                ccs_pkg::CCS_MSEL_EXT_DIV2: ref_r <= ext_cnt_r[0];
                default: ref_r <= 1'b0; // reserved code feeds nothing
            endcase
            periph_r <= ext_cnt_r[2];
        end
    end

    assign mul_ref_clk_out = ref_r;
    assign periph_ext_clk_out = periph_r;

    // ------------------------------------------------------------
    // glitch free system and usb selection
    // ------------------------------------------------------------
    // internal oscillator is passed without any readiness gate
    assign sys_src = {3'h0, lf_osc_in, mul_gated, mul_div2_r, ext_osc_in, int_osc_in};
    assign usb_src = {2'h0, ext_cnt_r[1], ext_div3_r, ext_cnt_r[0], ext_osc_in,
                      int_div2_r, mul_gated};

    ccs_glitch_mux #(.N(8), .SW(3)) u_sys_mux (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .src_in(sys_src),
        .sel_in(sys_sel_r),
        .clk_out(sys_clk),
        .busy_out(sys_busy)
    );

    ccs_glitch_mux #(.N(8), .SW(3)) u_usb_mux (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .src_in(usb_src),
        .sel_in(usb_sel_r),
        .clk_out(usb_clk),
        .busy_out(usb_busy)
    );

    assign sys_clk_out = sys_clk;
    assign usb_clk_out = usb_clk;

endmodule : ccs_clock_control

// [ccs_clock_control_asserts.sv]
// port level assertions for the clock multiplier and clock select block
`timescale 1ns/100ps

module ccs_clock_control_chk (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [ccs_pkg::CCS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic multiplier_enable_out,
    input wire logic multiplier_initialize_out,
    input wire logic sys_clk_out,
    input wire logic usb_clk_out,
    input wire logic periph_ext_clk_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    // ------------------------------------------------------------
    // completed accesses
    // ------------------------------------------------------------
    logic wr_mul;
    logic rd_ok;
    assign wr_mul = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
        && (avs_address_in == ccs_pkg::CCS_ADDR_MUL_CTRL);
    assign rd_ok = avs_read_in && !avs_waitrequest_out;

    // a clock high phase shorter than two cycles would be a runt
    sequence s_high2(s);
        s ##1 s;
    endsequence
    sequence s_init_req;
        wr_mul && multiplier_enable_out && (avs_writedata_in[7:6] == 2'b11);
    endsequence

    property p_en_follow;
        wr_mul |=> multiplier_enable_out == $past(avs_writedata_in[7]);
    endproperty
    property p_en_hold;
        !wr_mul |=> $stable(multiplier_enable_out);
    endproperty
    property p_init_gate;
        wr_mul && !multiplier_enable_out |=> !multiplier_initialize_out;
    endproperty
    property p_init_start;
        s_init_req |-> ##[1:2] multiplier_initialize_out;
    endproperty
    property p_init_drop;
        $fell(multiplier_enable_out) |-> ##[0:2] !multiplier_initialize_out;
    endproperty
    property p_mul_unused;
        rd_ok && (avs_address_in == ccs_pkg::CCS_ADDR_MUL_CTRL) |-> avs_readdata_out[4:2] == 3'h0;
    endproperty
    property p_sel_unused;
        rd_ok && (avs_address_in == ccs_pkg::CCS_ADDR_CLK_SEL)
            |-> !avs_readdata_out[7] && !avs_readdata_out[3];
    endproperty
    property p_sys_glitch;
        $rose(sys_clk_out) |-> s_high2(sys_clk_out);
    endproperty
    property p_usb_glitch;
        $rose(usb_clk_out) |-> s_high2(usb_clk_out);
    endproperty
    property p_periph;
        $changed(periph_ext_clk_out) |=> $stable(periph_ext_clk_out) [*8];
    endproperty

    a_en_follow: assert property (p_en_follow) else $error("enable not from write");
    a_en_hold: assert property (p_en_hold) else $error("enable moved unasked");
    a_init_gate: assert property (p_init_gate) else $error("init at enable");
    a_init_start: assert property (p_init_start) else $error("init not started");
    a_init_drop: assert property (p_init_drop) else $error("init kept when off");
    a_mul_unused: assert property (p_mul_unused) else $error("unused bits set");
    a_sel_unused: assert property (p_sel_unused) else $error("select bits 7 3 set");
    a_sys_glitch: assert property (p_sys_glitch) else $error("sys clock runt");
    a_usb_glitch: assert property (p_usb_glitch) else $error("usb clock runt");
    a_periph: assert property (p_periph) else $error("periph clock too fast");
endmodule : ccs_clock_control_chk

// [ccs_clock_control_tb.sv]
// self checking bench for the clock multiplier and clock select block
`timescale 1ns/100ps

module ccs_clock_control_tb;
    localparam logic [9:0] A_MUL = ccs_pkg::CCS_ADDR_MUL_CTRL;
    localparam logic [9:0] A_SEL = ccs_pkg::CCS_ADDR_CLK_SEL;
    localparam logic [9:0] A_ST = ccs_pkg::CCS_ADDR_STATUS;
    // source periods in system cycles, set by the oscillator loops below
    localparam int P_INT = 4;
    localparam int P_EXT = 6;
    localparam int P_LF = 14;
    localparam int P_MUL = 10;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [9:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = '0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wreq;
    logic int_osc = 1'b0;
    logic ext_osc = 1'b0;
    logic lf_osc = 1'b0;
    logic mul_clk = 1'b0;
    logic mul_lock = 1'b0;
    logic [2:0] xmode = 3'h0;
    logic xset = 1'b0;
    logic en_o, init_o, ref_o, sys_o, usb_o, per_o;
    int n_errors = 0;
    int n_tests = 0;

    ccs_clock_control dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .int_osc_in(int_osc), .ext_osc_in(ext_osc), .lf_osc_in(lf_osc), .mul_clk_in(mul_clk),
        .mul_lock_in(mul_lock), .external_oscillator_mode_in(xmode), .xtal_settled_in(xset),
        .multiplier_enable_out(en_o), .multiplier_initialize_out(init_o),
        .mul_ref_clk_out(ref_o), .sys_clk_out(sys_o), .usb_clk_out(usb_o),
        .periph_ext_clk_out(per_o));

    // sources are offset so no edge lands on a sampling edge
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #5;
        fork
            forever #50 int_osc = ~int_osc;
            forever #75 ext_osc = ~ext_osc;
            forever #175 lf_osc = ~lf_osc;
            forever #125 mul_clk = ~mul_clk;
        join
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // request held until waitrequest is seen low at a rising edge
    task automatic access(input logic w, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] b, output logic [31:0] q);
        int n;
        @(posedge clk_sys_in);
        adr <= a;
        wdat <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_errors++;
            stop_test();
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : access

    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, 4'hF, q);
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b0, a, 32'h0, 4'hF, q);
        check(what, q, exp);
    endtask : rd_chk

    // reads until the expected value shows, ten tries at most
    task automatic poll_mul(input logic [31:0] exp);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            access(1'b0, A_MUL, 32'h0, 4'hF, q);
            n++;
        end while (q !== exp && n < 10);
        check("mul ctrl poll", q, exp);
    endtask : poll_mul

    // cycles between two rising edges, -1 if none within the bound
    task automatic period(input int which, output int p);
        logic prv, cur;
        int n, t0;
        prv = 1'b1;
        t0 = -1;
        p = -1;
        for (n = 0; n < 400 && p < 0; n++) begin
            @(negedge clk_sys_in);
            cur = (which == 0) ? sys_o : (which == 1) ? usb_o : (which == 2) ? ref_o : per_o;
            if (cur === 1'b1 && prv === 1'b0) begin
                if (t0 >= 0) p = n - t0;
                t0 = n;
            end
            prv = cur;
        end
    endtask : period

    // first pass may straddle a switch, the second is judged
    task automatic chk_per(input string what, input int which, input int exp);
        int p;
        period(which, p);
        period(which, p);
        check(what, p, exp);
    endtask : chk_per

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs;
        logic [31:0] q;
        rd_chk("mul ctrl reset", A_MUL, 32'h00);
        rd_chk("clk sel reset", A_SEL, 32'h00);
        access(1'b1, A_SEL, 32'h11, 4'h0, q);
        rd_chk("masked write", A_SEL, 32'h00);
        wr_reg(10'h000, 32'hFF);
        rd_chk("unmapped", 10'h000, 32'h0);
    endtask : t_reset_regs

    task automatic t_mul;
        int refp[4] = '{P_INT, P_EXT, 2 * P_EXT, -1};
        wr_reg(A_MUL, 32'hC0);
        rd_chk("init at enable", A_MUL, 32'h80);
        check("enable out", {31'h0, en_o}, 32'h1);
        wr_reg(A_MUL, 32'h00);
        @(negedge clk_sys_in);
        check("disable out", {31'h0, en_o}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr_reg(A_MUL, 32'h80 | i);
            rd_chk("mul select", A_MUL, 32'h80 | i);
            chk_per("mul reference", 2, refp[i]);
        end
        wr_reg(A_MUL, 32'h80);
        repeat (220) @(posedge clk_sys_in);
        // stray ones in the unused bits ride along with the init write
        wr_reg(A_MUL, 32'hDC);
        rd_chk("init no lock", A_MUL, 32'hC0);
        check("init out", {31'h0, init_o}, 32'h1);
        mul_lock <= 1'b1;
        poll_mul(32'hE0);
        mul_lock <= 1'b0;
        poll_mul(32'hC0);
        mul_lock <= 1'b1;
        poll_mul(32'hE0);
    endtask : t_mul

    task automatic t_sys;
        int sp[5] = '{P_INT, P_EXT, 2 * P_MUL, P_MUL, P_LF};
        for (int i = 0; i < 5; i++) begin
            wr_reg(A_SEL, i);
            rd_chk("sys select", A_SEL, i);
            chk_per("sys clock", 0, sp[i]);
        end
        for (int i = 5; i < 8; i++) begin
            wr_reg(A_SEL, i);
            rd_chk("sys reserved", A_SEL, 32'h4);
        end
        wr_reg(A_SEL, 32'h0);
        chk_per("periph clock", 3, 8 * P_EXT);
    endtask : t_sys

    task automatic t_usb;
        int up[6] = '{P_MUL, 2 * P_INT, P_EXT, 2 * P_EXT, 3 * P_EXT, 4 * P_EXT};
        for (int i = 0; i < 6; i++) begin
            wr_reg(A_SEL, 32'h88 | (i << 4));
            rd_chk("usb select", A_SEL, i << 4);
            chk_per("usb clock", 1, up[i]);
        end
        for (int i = 6; i < 8; i++) begin
            wr_reg(A_SEL, i << 4);
            rd_chk("usb reserved", A_SEL, 32'h50);
        end
    endtask : t_usb

    task automatic t_crystal;
        logic [2:0] xm[5] = '{3'h4, 3'h6, 3'h6, 3'h7, 3'h3};
        logic xs[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [31:0] q;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_in);
            xmode <= xm[i];
            xset <= xs[i];
            access(1'b0, A_ST, 32'h0, 4'hF, q);
            check("crystal valid", {31'h0, q[0]}, (xm[i][2:1] == 2'h3) && xs[i]);
        end
        wr_reg(A_MUL, 32'h00);
        rd_chk("mul off", A_MUL, 32'h00);
    endtask : t_crystal

    initial begin
        repeat (10) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_reset_regs();
        t_mul();
        t_sys();
        t_usb();
        t_crystal();
        stop_test();
    end
endmodule : ccs_clock_control_tb

bind ccs_clock_control ccs_clock_control_chk chk_u (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .multiplier_enable_out(multiplier_enable_out),
    .multiplier_initialize_out(multiplier_initialize_out), .sys_clk_out(sys_clk_out),
    .usb_clk_out(usb_clk_out), .periph_ext_clk_out(periph_ext_clk_out));
